// ==== smtrg_top.sv ====
// Purpose: deceleration stop / pause control and trigger permit words
// Assumes: motion engine supplies positioning, repeat and end-point status
// Notes:   request and stop pins are synchronised before use
//          settings other than 0 and 1 act as a plain stop
//
// The implementer's own choice: strobed register access.
import smtrg_pkg::*;

// Operation
// - setting word selects decel stop action
// - setting 0: stop, repeat waits end point
// - setting 1: pause, resume on release
// - pause mode idle: plain stop, no resume
// - pause in repeat: stop at end point
// - system or emergency stop cancels pause
// - read-only registered-trigger flags word
// - writable trigger permit word
module smtrg_top (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        nrst_in,
  // register port
  input  wire logic [smtrg_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [smtrg_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [smtrg_pkg::DATA_W-1:0] rdata_out,
  // stop pins
  input  wire logic                        decel_req_in,
  input  wire logic                        sys_stop_in,
  input  wire logic                        emg_stop_in,
  // motion engine status
  input  wire logic                        positioning_in,
  input  wire logic                        repeat_in,
  input  wire logic                        end_point_in,
  // trigger engine
  input  wire logic [smtrg_pkg::NTRIG-1:0] trig_register_in,
  input  wire logic [smtrg_pkg::NTRIG-1:0] trig_unregister_in,
  // motion commands
  output logic                             decel_stop_out,
  output logic                             resume_out,
  output logic                             paused_out,
  output logic      [smtrg_pkg::NTRIG-1:0] trig_enable_out
);
  import smtrg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       req_s;
  logic       sys_s;
  logic       emg_s;

  smtrg_sync #(.W(3)) u_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({decel_req_in, sys_stop_in, emg_stop_in}),
    .q_out   (pins_s)
  );

  assign req_s = pins_s[2];
  assign sys_s = pins_s[1];
  assign emg_s = pins_s[0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] stop_sel_reg;
  logic [DATA_W-1:0] stop_sel_next;
  logic [NTRIG-1:0]  trig_reg_reg;
  logic [NTRIG-1:0]  trig_reg_next;
  logic [NTRIG-1:0]  trig_perm_reg;
  logic [NTRIG-1:0]  trig_perm_next;
  logic [DATA_W-1:0] rdata_next;
  logic              wr_sel;
  logic              wr_perm;
  logic              wr_set;
  logic [DATA_W-1:0] rdata_reg;
  logic [NTRIG-1:0]  trig_enable_reg;
  logic [NTRIG-1:0]  trig_enable_next;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // write-enable mux shared by both writable words
  function automatic logic [DATA_W-1:0] take_word(
    input logic              en,
    input logic [DATA_W-1:0] d,
    input logic [DATA_W-1:0] q
  );
    take_word = en ? d : q;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // only writes are decoded here; reads have their own mux below
  always_comb begin
    wr_sel  = wr_in && hit(addr_in, ADDR_STOP_SEL);
    wr_perm = wr_in && hit(addr_in, ADDR_TRIG_PERM);
    wr_set  = wr_in && hit(addr_in, ADDR_TRIG_SET);
  end

  // ----------------------------------------------------------------
  // word update
  // ----------------------------------------------------------------
  always_comb begin
    stop_sel_next  = take_word(wr_sel, wdata_in, stop_sel_reg);
    trig_perm_next = take_word(wr_perm, wdata_in, trig_perm_reg);
    // registration is hardware driven; software may only withdraw it,
    // and a registration in the same cycle wins over the withdrawal
    trig_reg_next  = trig_reg_reg & ~trig_unregister_in;
    if (wr_set) begin
      trig_reg_next = trig_reg_next & ~wdata_in;
    end
    trig_reg_next  = trig_reg_next | trig_register_in;
  end

  // ----------------------------------------------------------------
  // stop / pause sequencer
  // ----------------------------------------------------------------
  smtrg_state_t state_reg;
  smtrg_state_t state_next;
  logic         req_d_reg;
  logic         req_d_next;
  logic         resumable_reg;
  logic         resumable_next;
  logic         decel_next;
  logic         resume_next;
  logic         req_rise;
  logic         req_fall;
  logic         pause_mode;
  logic         hard_stop;
  logic         decel_stop_reg;
  logic         resume_reg;
  logic         paused_reg;
  logic         paused_next;

  // pause state decode, shared by the status word and the pause flag
  function automatic logic is_paused(input smtrg_state_t st);
    is_paused = (st == SMT_PAUSED);
  endfunction

  // status word: paused, waiting for the end point, resume armed
  function automatic logic [DATA_W-1:0] status_word(
    input smtrg_state_t st,
    input logic         armed
  );
    status_word                  = RST_WORD;
    status_word[ST_PAUSED_BIT]   = is_paused(st);
    status_word[ST_STOPPING_BIT] = (st == SMT_STOPPING);
    status_word[ST_ARMED_BIT]    = armed;
  endfunction

  // ----------------------------------------------------------------
  // request edge detector
  // ----------------------------------------------------------------
  // the delay flop resets low like the idle pin, so no false edge after reset
  always_comb begin
    req_d_next = req_s;
    req_rise   = req_s && !req_d_reg;
    req_fall   = !req_s && req_d_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_d_reg <= 1'b0;
    end else begin
      req_d_reg <= req_d_next;
    end
  end

  // a hard stop outranks both the end point and the release
  always_comb begin
    pause_mode     = (stop_sel_reg == SEL_PAUSE);
    hard_stop      = sys_s || emg_s;
    state_next     = state_reg;
    resumable_next = resumable_reg;
    decel_next     = 1'b0;
    resume_next    = 1'b0;
    case (state_reg)
      SMT_IDLE: begin
        if (req_rise && !hard_stop) begin
          // resume only when a positioning run was actually cut short
          resumable_next = pause_mode && positioning_in;
          if (repeat_in) begin
            state_next = SMT_STOPPING;
          end else begin
            decel_next = 1'b1;
            state_next = SMT_PAUSED;
          end
        end
      end
      SMT_STOPPING: begin
        // repeat run continues to the targeted end point, then stops
        if (hard_stop) begin
          resumable_next = 1'b0;
          state_next     = SMT_IDLE;
        end else if (end_point_in) begin
          decel_next = 1'b1;
          state_next = SMT_PAUSED;
        end
      end
      SMT_PAUSED: begin
        if (hard_stop) begin
          resumable_next = 1'b0;
          state_next     = SMT_IDLE;
        end else if (req_fall) begin
          resume_next    = resumable_reg;
          resumable_next = 1'b0;
          state_next     = SMT_IDLE;
        end
      end
      default: begin
        state_next     = SMT_IDLE;
        resumable_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = RST_WORD;
    if (rd_in) begin
      case (addr_in)
        ADDR_STOP_SEL:  rdata_next = stop_sel_reg;
        ADDR_TRIG_REG:  rdata_next = trig_reg_reg;
        ADDR_TRIG_PERM: rdata_next = trig_perm_reg;
        ADDR_STATUS:    rdata_next = status_word(state_reg, resumable_reg);
        default:        rdata_next = RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output words
  // ----------------------------------------------------------------
  // enable and pause flag are registered from the next values, so they
  // change on the same edge as the words they are built from
  always_comb begin
    trig_enable_next = trig_perm_next & trig_reg_next;
    paused_next      = is_paused(state_next) && resumable_next;
  end

  // ----------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stop_sel_reg    <= RST_WORD;
      trig_reg_reg    <= RST_WORD;
      trig_perm_reg   <= RST_WORD;
      trig_enable_reg <= RST_WORD;
    end else begin
      stop_sel_reg    <= stop_sel_next;
      trig_reg_reg    <= trig_reg_next;
      trig_perm_reg   <= trig_perm_next;
      trig_enable_reg <= trig_enable_next;
    end
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg      <= SMT_IDLE;
      resumable_reg  <= 1'b0;
      decel_stop_reg <= 1'b0;
      resume_reg     <= 1'b0;
      paused_reg     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      resumable_reg  <= resumable_next;
      decel_stop_reg <= decel_next;
      resume_reg     <= resume_next;
      paused_reg     <= paused_next;
    end
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  // cleared outside the read slot so a stale word never lingers on the port
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out       = rdata_reg;
  assign decel_stop_out  = decel_stop_reg;
  assign resume_out      = resume_reg;
  assign paused_out      = paused_reg;
  // permit gates only triggers that are registered
  assign trig_enable_out = trig_enable_reg;
endmodule

// ==== smtrg_pkg.sv ====
// Purpose: shared constants for the stop-mode and trigger-enable block
// Assumes: registers are word addressed by unit memory number
// Notes:   all words are 16 bits wide and reset to zero
package smtrg_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          NTRIG           = 16;
  localparam logic [15:0] ADDR_STOP_SEL   = 16'h261D;
  localparam logic [15:0] ADDR_TRIG_REG   = 16'h2630;
  localparam logic [15:0] ADDR_TRIG_PERM  = 16'h2631;
  localparam logic [15:0] ADDR_TRIG_SET   = 16'h2640;
  localparam logic [15:0] ADDR_STATUS     = 16'h2641;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  // ----------------------------------------------------------------
  // setting values and status fields
  // ----------------------------------------------------------------
  localparam logic [15:0] SEL_DECEL       = 16'h0000;
  localparam logic [15:0] SEL_PAUSE       = 16'h0001;
  localparam int          ST_PAUSED_BIT   = 0;
  localparam int          ST_STOPPING_BIT = 1;
  localparam int          ST_ARMED_BIT    = 2;
  typedef enum logic [1:0] {SMT_IDLE, SMT_STOPPING, SMT_PAUSED} smtrg_state_t;
endpackage

// ==== smtrg_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to mclk_in
// Notes:   first stage feeds only the second stage
module smtrg_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] q_next;

  always_comb begin
    s1_next = d_in;
    q_next  = s1_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_reg <= '0;
      q_out  <= '0;
    end else begin
      s1_reg <= s1_next;
      q_out  <= q_next;
    end
  end
endmodule

// ==== smtrg_chk.sv ====
// Purpose: port checker for smtrg_top
// Assumes: one clock, reset async low
// Notes:   permit shadow follows host writes
module smtrg_chk import smtrg_pkg::*; (
  input wire logic        mclk_in, nrst_in, wr_in, rd_in, decel_req_in,
  input wire logic        sys_stop_in, emg_stop_in, end_point_in,
  input wire logic        decel_stop_out, resume_out, paused_out,
  input wire logic [15:0] addr_in, wdata_in, rdata_out, trig_enable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] perm_reg;
  always_ff @(posedge mclk_in or negedge nrst_in)
    if (!nrst_in) perm_reg <= 16'h0000;
    else if (wr_in && addr_in == ADDR_TRIG_PERM) perm_reg <= wdata_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  chk_rd_perm: assert property (rd_in && addr_in == ADDR_TRIG_PERM |=> rdata_out == perm_reg)
    else $error("permit word read back wrong");
  chk_en_perm: assert property ($stable(perm_reg) |-> (trig_enable_out & ~perm_reg) == 16'h0000)
    else $error("forbidden trigger enabled");
  chk_stop_src: assert property (decel_stop_out |->
    ($past(decel_req_in, 3) && !$past(decel_req_in, 4)) || $past(end_point_in))
    else $error("stop without request edge or end point");
  chk_res_src: assert property (resume_out |->
    !$past(decel_req_in, 3) && $past(decel_req_in, 4) && $past(paused_out))
    else $error("resume without release from pause");
  chk_stop_one: assert property (decel_stop_out |=> !decel_stop_out)
    else $error("stop pulse too long");
  chk_pause_src: assert property ($rose(paused_out) |-> decel_stop_out)
    else $error("pause without stop");
  chk_stop_cancel: assert property ((sys_stop_in || emg_stop_in) [*4] |->
    !paused_out && !resume_out)
    else $error("pause kept through system stop");
endmodule

// ==== smtrg_motion.sv ====
// Purpose: motion engine stand-in for the stop pins
// Assumes: end point met every EP_GAP cycles in repeat
// Notes:   stop halts motion until resume or run drop
module smtrg_motion #(parameter int EP_GAP = 10) (
  input  wire logic mclk_in, nrst_in, run_in, rpt_in, decel_stop_in, resume_in,
  output logic      positioning_out, repeat_out, end_point_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic halt_reg;
  int   cnt;
  always_ff @(posedge mclk_in or negedge nrst_in)
    if (!nrst_in) begin
      halt_reg <= 1'b0;
      cnt <= 0;
    end else begin
      if (decel_stop_in) halt_reg <= 1'b1;
      else if (resume_in || !run_in) halt_reg <= 1'b0;
      cnt <= (rpt_in && cnt < EP_GAP - 1) ? cnt + 1 : 0;
    end
  assign positioning_out = run_in && !halt_reg;
  assign repeat_out = rpt_in && !halt_reg;
  assign end_point_out = repeat_out && cnt == EP_GAP - 1;
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench for smtrg_top
// Assumes: inputs change just after rising edges
// Notes:   random permit and trigger words, fixed seed
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smtrg_pkg::*;
  logic mclk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, req = 0, sys = 0, emg = 0;
  logic run = 0, rpt = 0, pos, rp, ep, dstop, res, pau;
  logic [15:0] addr_in = 0, wdata_in = 0, rdata_out, treg = 0, tunreg = 0, ten;
  int err_count = 0, cmp_count = 0, nstop = 0, nres = 0;
  always #20 mclk_in = ~mclk_in;
  smtrg_top u_dut (.mclk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .decel_req_in(req), .sys_stop_in(sys), .emg_stop_in(emg), .positioning_in(pos),
    .repeat_in(rp), .end_point_in(ep), .trig_register_in(treg), .trig_unregister_in(tunreg),
    .decel_stop_out(dstop), .resume_out(res), .paused_out(pau), .trig_enable_out(ten));
  smtrg_motion u_mot (.mclk_in, .nrst_in, .run_in(run), .rpt_in(rpt), .decel_stop_in(dstop),
    .resume_in(res), .positioning_out(pos), .repeat_out(rp), .end_point_out(ep));
  always @(posedge mclk_in) begin
    nstop += (dstop === 1'b1);
    nres += (res === 1'b1);
  end
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic armed(logic [15:0] sel, logic r);
    return (sel == SEL_PAUSE) && r;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge mclk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge mclk_in) wr_in <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] exp, string nm);
    @(posedge mclk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge mclk_in) rd_in <= 1'b0;
    #1 chk(nm, exp, rdata_out);
  endtask
  // kill: 1 system stop, 2 emergency stop while paused
  task automatic stopseq(logic [15:0] sel, logic r, logic p, int kill, int es, int er);
    wr(ADDR_STOP_SEL, sel);
    run <= r;
    rpt <= p;
    cyc(4);
    nstop = 0;
    nres = 0;
    req <= 1'b1;
    cyc(30);
    chk("stop count", 16'(es), 16'(nstop));
    chk("paused", {15'h0, armed(sel, r)}, {15'h0, pau});
    rd(ADDR_STATUS, {13'h0, armed(sel, r), 2'h1}, "status");
    cyc(1);
    if (kill == 1) sys <= 1'b1;
    else if (kill == 2) emg <= 1'b1;
    cyc(6);
    chk("paused after stop", {15'h0, armed(sel, r) && kill == 0}, {15'h0, pau});
    {req, sys, emg} <= 3'h0;
    cyc(8);
    chk("resume count", 16'(er), 16'(nres));
    chk("paused released", 16'h0000, {15'h0, pau});
    {run, rpt} <= 2'h0;
    cyc(4);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    logic [15:0] v, t;
    v = $urandom(14);
    cyc(5);
    nrst_in <= 1'b1;
    rd(ADDR_STOP_SEL, 16'h0000, "stop sel");
    rd(ADDR_TRIG_REG, 16'h0000, "flags");
    rd(ADDR_TRIG_PERM, 16'h0000, "permit");
    rd(16'h0000, 16'h0000, "unmapped");
    wr(ADDR_STOP_SEL, SEL_PAUSE);
    rd(ADDR_STOP_SEL, SEL_PAUSE, "stop sel");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      t = (i == 1) ? 16'h8001 : 16'($urandom);
      wr(ADDR_TRIG_PERM, v);
      rd(ADDR_TRIG_PERM, v, "permit");
      @(posedge mclk_in) treg <= t;
      @(posedge mclk_in) treg <= 16'h0000;
      wr(ADDR_TRIG_REG, ~t);
      rd(ADDR_TRIG_REG, t, "flags");
      chk("enable", v & t, ten);
      @(posedge mclk_in) tunreg <= t;
      @(posedge mclk_in) tunreg <= 16'h0000;
      rd(ADDR_TRIG_REG, 16'h0000, "flags gone");
      @(posedge mclk_in) {treg, tunreg} <= {t, t};
      @(posedge mclk_in) {treg, tunreg} <= 32'h0;
      rd(ADDR_TRIG_REG, t, "set wins");
      wr(ADDR_TRIG_SET, t & 16'h00FF);
      rd(ADDR_TRIG_REG, t & 16'hFF00, "flags w1c");
      chk("enable w1c", v & t & 16'hFF00, ten);
      @(posedge mclk_in) tunreg <= t;
      @(posedge mclk_in) tunreg <= 16'h0000;
    end
    stopseq(SEL_DECEL, 1, 0, 0, 1, 0);
    stopseq(SEL_DECEL, 1, 1, 0, 1, 0);
    stopseq(SEL_PAUSE, 1, 0, 0, 1, 1);
    stopseq(SEL_PAUSE, 0, 0, 0, 1, 0);
    stopseq(SEL_PAUSE, 1, 1, 0, 1, 1);
    stopseq(SEL_PAUSE, 1, 0, 1, 1, 0);
    stopseq(SEL_PAUSE, 1, 0, 2, 1, 0);
    stop_test();
  end
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule
bind smtrg_top smtrg_chk u_chk (.mclk_in, .nrst_in, .wr_in, .rd_in, .decel_req_in,
  .sys_stop_in, .emg_stop_in, .end_point_in, .decel_stop_out, .resume_out, .paused_out,
  .addr_in, .wdata_in, .rdata_out, .trig_enable_out);
